/* core/rsmr_pkg.sv */
// Purpose: Constants and types for the rail setpoint and mode register bank
// Assumes: Byte-wide registers on an internal register port
// Notes: Reset values per rail; variant picks the mode bit reset
`default_nettype none
package rsmr_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CODE_W = 7;
   localparam logic [7:0] OFS_RAIL1 = 8'h20;
   localparam logic [7:0] OFS_RAIL2 = 8'h21;
   localparam logic [7:0] OFS_RAIL3 = 8'h23;
   localparam logic [7:0] OFS_RAIL4 = 8'h25;
   localparam logic [7:0] OFS_RAIL5 = 8'h26;
   localparam logic [7:0] OFS_GAP = 8'h22;
   localparam logic [7:0] RST_RAIL1 = 8'h38;
   localparam logic [7:0] RST_RAIL2 = 8'h00;
   localparam logic [7:0] RST_RAIL3 = 8'h11;
   localparam logic [7:0] RST_MODE = 8'h3D;
   localparam logic [7:0] RST_MODE_PWM = 8'h3F;
   localparam logic [7:0] MODE_WR_MASK = 8'h3F;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [6:0] ZERO_CODE = 7'h00;
   localparam int unsigned MODE_BIT = 1;

   typedef struct packed {
      logic [7:0] rail1;
      logic [7:0] rail2;
      logic [7:0] rail3;
      logic [7:0] rail4;
      logic [7:0] rail5;
      logic [7:0] rdata;
      logic rvalid;
      logic pgood_hold;
   } rsmr_state_type;
endpackage
`default_nettype wire

/* core/rsmr_regs.sv */
// Purpose: Rail voltage code and switching mode registers
// Assumes: Register port driven by the target bus logic, one access per strobe
// Notes: Read data valid one cycle after a read strobe
`timescale 1ns/10ps
`default_nettype none
module rsmr_regs #(
   parameter bit PWM_VARIANT = 1'b0
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [rsmr_pkg::ADDR_W-1:0] i_addr,
   input wire logic [rsmr_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_sleep_state_n,
   output logic [rsmr_pkg::DATA_W-1:0] o_rdata,
   output logic o_rvalid,
   output logic [rsmr_pkg::CODE_W-1:0] o_rail1_target_code,
   output logic [rsmr_pkg::CODE_W-1:0] o_rail2_target_code,
   output logic [rsmr_pkg::CODE_W-1:0] o_rail3_target_code,
   output logic o_rail4_force_pwm,
   output logic o_rail5_force_pwm,
   output logic o_pgood_hold
);
   // ------------------------------------------------
   // State
   // ------------------------------------------------
   rsmr_pkg::rsmr_state_type state_r;
   rsmr_pkg::rsmr_state_type state_nxt;
   logic [7:0] mode_rst;

   assign mode_rst = PWM_VARIANT ? rsmr_pkg::RST_MODE_PWM : rsmr_pkg::RST_MODE;

   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                           input rsmr_pkg::rsmr_state_type s);
      begin
         unique case (a)
            rsmr_pkg::OFS_RAIL1: read_mux = s.rail1;
            rsmr_pkg::OFS_RAIL2: read_mux = s.rail2;
            rsmr_pkg::OFS_RAIL3: read_mux = s.rail3;
            rsmr_pkg::OFS_RAIL4: read_mux = s.rail4;
            rsmr_pkg::OFS_RAIL5: read_mux = s.rail5;
            default: read_mux = rsmr_pkg::ZERO_BYTE;
         endcase
      end
   endfunction

   // ------------------------------------------------
   // Next state
   // ------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.rvalid = i_rd;
      if (i_rd)
      begin
         state_nxt.rdata = read_mux(i_addr, state_r);
      end
      if (i_wr)
      begin
         unique case (i_addr)
            rsmr_pkg::OFS_RAIL1: state_nxt.rail1 = i_wdata;
            rsmr_pkg::OFS_RAIL2: state_nxt.rail2 = i_wdata;
            rsmr_pkg::OFS_RAIL3: state_nxt.rail3 = i_wdata;
            rsmr_pkg::OFS_RAIL4: state_nxt.rail4 = i_wdata & rsmr_pkg::MODE_WR_MASK;
            rsmr_pkg::OFS_RAIL5: state_nxt.rail5 = i_wdata & rsmr_pkg::MODE_WR_MASK;
            default: state_nxt.rail1 = state_r.rail1;
         endcase
      end
      // Power goods forced high on zero code or sleep
      state_nxt.pgood_hold = !i_sleep_state_n
         || state_nxt.rail1[6:0] == rsmr_pkg::ZERO_CODE
         || state_nxt.rail2[6:0] == rsmr_pkg::ZERO_CODE
         || state_nxt.rail3[6:0] == rsmr_pkg::ZERO_CODE;
      if (i_sys_rst)
      begin
         state_nxt.rail1 = rsmr_pkg::RST_RAIL1;
         state_nxt.rail2 = rsmr_pkg::RST_RAIL2;
         state_nxt.rail3 = rsmr_pkg::RST_RAIL3;
         state_nxt.rail4 = mode_rst;
         state_nxt.rail5 = mode_rst;
         state_nxt.rdata = rsmr_pkg::ZERO_BYTE;
         state_nxt.rvalid = 1'b0;
         state_nxt.pgood_hold = 1'b1;
      end
   end

   always_ff @(posedge i_clock)
   begin
      state_r <= state_nxt;
   end

   // ------------------------------------------------
   // Outputs
   // ------------------------------------------------
   // Bit 7 of code registers reaches no regulator
   assign o_rail1_target_code = state_r.rail1[6:0];
   assign o_rail2_target_code = state_r.rail2[6:0];
   assign o_rail3_target_code = state_r.rail3[6:0];
   assign o_rail4_force_pwm = state_r.rail4[rsmr_pkg::MODE_BIT];
   assign o_rail5_force_pwm = state_r.rail5[rsmr_pkg::MODE_BIT];
   assign o_rdata = state_r.rdata;
   assign o_rvalid = state_r.rvalid;
   assign o_pgood_hold = state_r.pgood_hold;

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------
   AST_RAIL1_RST: assert property (@(posedge i_clock)
      i_sys_rst |=> state_r.rail1 == rsmr_pkg::RST_RAIL1)
   else
      $error("rail1 reset wrong");

   AST_RAIL2_RST: assert property (@(posedge i_clock)
      i_sys_rst |=> state_r.rail2 == rsmr_pkg::RST_RAIL2)
   else
      $error("rail2 reset wrong");

   AST_RAIL3_RST: assert property (@(posedge i_clock)
      i_sys_rst |=> o_rail3_target_code == rsmr_pkg::RST_RAIL3[rsmr_pkg::CODE_W-1:0])
   else
      $error("rail3 reset wrong");

   AST_PGOOD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !i_sleep_state_n |=> o_pgood_hold)
   else
      $error("pgood not held in sleep");

   AST_PGOOD_ZERO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_rail1_target_code == rsmr_pkg::ZERO_CODE || o_rail2_target_code == rsmr_pkg::ZERO_CODE
      || o_rail3_target_code == rsmr_pkg::ZERO_CODE |-> o_pgood_hold)
   else
      $error("pgood not held on zero code");

   AST_ZERO_ACCEPT: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_RAIL1 && i_wdata[rsmr_pkg::CODE_W-1:0] == rsmr_pkg::ZERO_CODE
      |=> o_rail1_target_code == rsmr_pkg::ZERO_CODE)
   else
      $error("zero code not accepted");

   AST_PWM4: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_RAIL4
      |=> o_rail4_force_pwm == $past(i_wdata[rsmr_pkg::MODE_BIT]))
   else
      $error("rail4 mode not written");

   AST_PWM5: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_RAIL5
      |=> o_rail5_force_pwm == $past(i_wdata[rsmr_pkg::MODE_BIT]))
   else
      $error("rail5 mode not written");

   AST_MODE4_RO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (state_r.rail4 & ~rsmr_pkg::MODE_WR_MASK) == rsmr_pkg::ZERO_BYTE)
   else
      $error("rail4 read-only bits set");

   AST_MODE5_RO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (state_r.rail5 & ~rsmr_pkg::MODE_WR_MASK) == rsmr_pkg::ZERO_BYTE)
   else
      $error("rail5 read-only bits set");

   AST_MODE4_RST: assert property (@(posedge i_clock)
      i_sys_rst |=> state_r.rail4 == mode_rst)
   else
      $error("rail4 reset wrong");

   AST_MODE5_RST: assert property (@(posedge i_clock)
      i_sys_rst |=> state_r.rail5 == mode_rst)
   else
      $error("rail5 reset wrong");

   AST_RESV7: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_RAIL2 ##1 i_rd && !i_wr && i_addr == rsmr_pkg::OFS_RAIL2
      |=> o_rdata == $past(i_wdata, 2))
   else
      $error("code readback wrong");

   AST_CODE_WR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_RAIL3 |=> state_r.rail3 == $past(i_wdata))
   else
      $error("rail3 code not stored whole");

   AST_RVALID_SET: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_rd |=> o_rvalid)
   else
      $error("read not answered");

   AST_RVALID_PULSE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !i_rd |=> !o_rvalid)
   else
      $error("read valid without read");

   AST_UNMAPPED: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr && i_addr == rsmr_pkg::OFS_GAP
      |=> $stable(state_r.rail1) && $stable(state_r.rail2) && $stable(state_r.rail3))
   else
      $error("unmapped write changed state");

   AST_RD_UNMAPPED: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_rd && i_addr == rsmr_pkg::OFS_GAP |=> o_rdata == rsmr_pkg::ZERO_BYTE)
   else
      $error("unmapped read not zero");

   // ------------------------------------------------
   // Covers
   // ------------------------------------------------
   COV_PWM4: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      $rose(o_rail4_force_pwm));

   COV_ZERO: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      o_rail1_target_code == rsmr_pkg::ZERO_CODE);

   COV_READ: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      o_rvalid && o_rdata == rsmr_pkg::RST_RAIL3);

   COV_SLEEP: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      !i_sleep_state_n ##1 o_pgood_hold);

   COV_WR_RD: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      i_wr ##1 i_rd);
endmodule
`default_nettype wire

/* tb/rsmr_host_model.sv */
// Purpose: Host side of the register port, one byte per access
// Assumes: Read answer lands one cycle after the read strobe
// Notes: Released data and address lines show the inverted last value
`timescale 1ns/10ps
`default_nettype none
module rsmr_host_model (
   input wire logic i_clock,
   output logic o_wr,
   output logic o_rd,
   output logic [rsmr_pkg::ADDR_W-1:0] o_addr,
   output logic [rsmr_pkg::DATA_W-1:0] o_wdata
);
   initial
   begin
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= 8'h00;
      o_wdata <= 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
      @(posedge i_clock);
      {o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d};
   endtask
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
      @(posedge i_clock);
      {o_wr, o_rd} <= 2'h1;
      @(posedge i_clock);
      {o_rd, o_addr, o_wdata} <= {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clock);
      {o_rd, o_addr} <= {1'b1, a};
      @(posedge i_clock);
      {o_rd, o_addr} <= {1'b0, ~a};
   endtask
endmodule
`default_nettype wire

/* tb/test_rsmr_regs.sv */
// Purpose: Self-checking bench for the rail register bank
// Assumes: Default variant for dut, mode registers reset to 0x3D; dut_pwm is the PWM variant, reset 0x3F
// Notes: Host model makes every access
`timescale 1ns/10ps
`default_nettype none
module test_rsmr_regs;
   logic i_clock, i_sys_rst, wr, rd, sleep_n, rvalid, pwm4, pwm5, hold;
   logic [7:0] addr, wdata, rdata;
   logic [6:0] c1, c2, c3;
   logic pwm4_v, pwm5_v;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] ofs [5] = '{8'h20, 8'h21, 8'h23, 8'h25, 8'h26};
   logic [7:0] rv [5] = '{8'h38, 8'h00, 8'h11, 8'h3D, 8'h3D};
   rsmr_host_model host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   rsmr_regs dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
      .i_wdata(wdata), .i_sleep_state_n(sleep_n), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_rail1_target_code(c1), .o_rail2_target_code(c2), .o_rail3_target_code(c3),
      .o_rail4_force_pwm(pwm4), .o_rail5_force_pwm(pwm5), .o_pgood_hold(hold));
   rsmr_regs #(.PWM_VARIANT(1'b1)) dut_pwm (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr(wr),
      .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_sleep_state_n(sleep_n), .o_rdata(),
      .o_rvalid(), .o_rail1_target_code(), .o_rail2_target_code(), .o_rail3_target_code(),
      .o_rail4_force_pwm(pwm4_v), .o_rail5_force_pwm(pwm5_v), .o_pgood_hold());
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a);
      #1;
      check({rvalid, rdata}, {1'b1, exp});
   endtask
   task automatic outs(input logic [31:0] exp);
      #1;
      check({1'b0, c1, 1'b0, c2, 1'b0, c3, 5'h00, pwm4, pwm5, hold}, exp);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial
   begin
      i_sys_rst <= 1'b1;
      sleep_n <= 1'b1;
      repeat (6) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      outs(32'h38001101);
      check({30'h0, pwm4_v, pwm5_v}, 32'h3);
      for (int i = 0; i < 5; i++)
         rd_chk(ofs[i], rv[i]);
      for (int i = 0; i < 5; i++)
         host.wr(ofs[i], 8'hFF);
      outs(32'h7F7F7F06);
      for (int i = 0; i < 5; i++)
         rd_chk(ofs[i], (i > 2) ? 8'h3F : 8'hFF);
      host.wr(8'h20, 8'h80);
      outs(32'h007F7F07);
      rd_chk(8'h20, 8'h80);
      host.wr(8'h25, 8'hFD);
      host.wr(8'h26, 8'h02);
      host.wr(8'h20, 8'h01);
      outs(32'h017F7F02);
      rd_chk(8'h25, 8'h3D);
      rd_chk(8'h26, 8'h02);
      host.wr(8'h22, 8'h00);
      rd_chk(8'h22, 8'h00);
      rd_chk(8'h21, 8'hFF);
      host.wr_rd(8'h21, 8'hA5);
      #1;
      check({rvalid, rdata}, {1'b1, 8'hA5});
      @(posedge i_clock);
      sleep_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      outs(32'h01257F03);
      @(posedge i_clock);
      sleep_n <= 1'b1;
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      outs(32'h38001101);
      rd_chk(8'h25, 8'h3D);
      print_verdict();
   end
endmodule
`default_nettype wire
